// File: inc/wgss_pkg.sv
// package: register map, field layout and source codes of the waveform source select block
package wgss_pkg;
    // ==========================================================
    // register offsets (byte-wide registers on a plain port)
    localparam logic [3:0] off_clock_select = 4'h0;
    localparam logic [3:0] off_input_select = 4'h1;
    localparam logic [3:0] off_rising_deadband = 4'h2;
    localparam logic [3:0] off_falling_deadband = 4'h3;
    localparam logic [3:0] off_main_control = 4'h4;
    localparam logic [3:0] off_polarity_control = 4'h5;
    localparam logic [3:0] off_shutdown_control = 4'h6;
    localparam logic [3:0] off_shutdown_source = 4'h7;
    localparam logic [3:0] off_steering_control = 4'h8;

    // ==========================================================
    // field positions
    localparam int pos_clock_source = 0;
    localparam int pos_main_enable = 7;
    localparam int pos_main_load = 6;
    localparam int pos_override_lsb = 4;
    localparam int pos_steer_lsb = 0;
    localparam int pos_polarity_lsb = 0;
    localparam int pos_input_status = 5;

    // ==========================================================
    // reset values and masks
    localparam logic [7:0] rst_register = 8'h00;
    localparam logic [7:0] mask_clock_select = 8'h01;
    localparam logic [7:0] mask_input_select = 8'h0f;
    localparam logic [7:0] mask_deadband = 8'h3f;
    localparam logic [7:0] mask_main_control = 8'hc7;
    localparam logic [7:0] mask_polarity_rw = 8'h0f;
    localparam logic [7:0] mask_shutdown_control = 8'hfc;
    localparam logic [7:0] mask_shutdown_source = 8'h7f;
    localparam logic [2:0] mode_buffered_steer = 3'h1;

    // ==========================================================
    // input source codes
    localparam logic [3:0] src_routed_pin = 4'h0;
    localparam logic [3:0] src_capture_first = 4'h1;
    localparam logic [3:0] src_pwm_six = 4'h6;
    localparam logic [3:0] src_numeric_osc = 4'h8;
    localparam logic [3:0] src_comparator_first = 4'h9;
    localparam logic [3:0] src_modulator = 4'hb;
    localparam logic [3:0] src_logic_first = 4'hc;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wgss_bus_type;

    // on-chip waveform sources
    typedef struct packed {
        logic routed_input_pin;
        logic [4:0] capture_compare_output;
        logic pwm_six_output;
        logic pwm_seven_output;
        logic numeric_oscillator_output;
        logic comparator_one_synced;
        logic comparator_two_synced;
        logic signal_modulator_output;
        logic [3:0] logic_cell_output;
    } wgss_sources_type;
endpackage

// File: logic/wgss_source_select.sv
// waveform generator source select, clock select, register file and steering
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Contract
// - clock select bit one picks fast oscillator
// - four-bit field picks generator data source
// - mode 001 makes steering enables double-buffered
// - unused select bits ignore writes, read zero
// - clock and input selects reset to zero
// - steered output carries data through polarity
// - unsteered output carries its override bit
module wgss_source_select (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wgss_pkg::wgss_bus_type bus,
    output logic [7:0] rdata,
    input wgss_pkg::wgss_sources_type sources,
    input wire logic internal_fast_oscillator,
    input wire logic update_point,
    output logic clock_source_fast,
    output logic generator_data_waveform,
    output logic [3:0] channel_out
);
    // ==========================================================
    // registers
    logic clock_select;
    logic [3:0] input_source_field;
    logic [7:0] rising_deadband_count;
    logic [7:0] falling_deadband_count;
    logic [7:0] waveform_main_control;
    logic [7:0] output_polarity_control;
    logic [7:0] shutdown_control;
    logic [7:0] shutdown_source_enable;
    logic [7:0] output_steering_control;

    // working signals; the fast oscillator input only feeds the clock
    // mux beside this block, so no logic in here reads it
    logic [1:0] pin_sync;
    logic next_data;
    wire logic [3:0] next_channel;
    logic buffered_mode;
    logic steer_load;

    // routed pin comes from outside, so two flops first; the other
    // sources are made on this clock and need no synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], sources.routed_input_pin};
        end
    end

    // ==========================================================
    // register writes; upper bits of the selects are simply not stored,
    // which is what makes them read back as zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_select <= wgss_pkg::rst_register[0];
            input_source_field <= wgss_pkg::rst_register[3:0];
            rising_deadband_count <= wgss_pkg::rst_register;
            falling_deadband_count <= wgss_pkg::rst_register;
            waveform_main_control <= wgss_pkg::rst_register;
            output_polarity_control <= wgss_pkg::rst_register;
            shutdown_control <= wgss_pkg::rst_register;
            shutdown_source_enable <= wgss_pkg::rst_register;
            output_steering_control <= wgss_pkg::rst_register;
        end else if (bus.wr) begin
            case (bus.addr)
                wgss_pkg::off_clock_select: begin
                    clock_select <= bus.wdata[wgss_pkg::pos_clock_source];
                end
                wgss_pkg::off_input_select: begin
                    input_source_field <= bus.wdata[3:0];
                end
                wgss_pkg::off_rising_deadband: begin
                    rising_deadband_count <= bus.wdata & wgss_pkg::mask_deadband;
                end
                wgss_pkg::off_falling_deadband: begin
                    falling_deadband_count <= bus.wdata & wgss_pkg::mask_deadband;
                end
                wgss_pkg::off_main_control: begin
                    waveform_main_control <= bus.wdata & wgss_pkg::mask_main_control;
                end
                wgss_pkg::off_polarity_control: begin
                    output_polarity_control <= bus.wdata & wgss_pkg::mask_polarity_rw;
                end
                wgss_pkg::off_shutdown_control: begin
                    shutdown_control <= bus.wdata & wgss_pkg::mask_shutdown_control;
                end
                wgss_pkg::off_shutdown_source: begin
                    shutdown_source_enable <= bus.wdata & wgss_pkg::mask_shutdown_source;
                end
                wgss_pkg::off_steering_control: begin
                    output_steering_control <= bus.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign buffered_mode = (waveform_main_control[2:0] == wgss_pkg::mode_buffered_steer);

    // ==========================================================
    // steering lanes; buffered mode holds the enables until the update
    // point, so a write in mid-period cannot cut a pulse on one channel
    assign steer_load = !buffered_mode || update_point;

    for (genvar ch = 0; ch < 4; ch++) begin : lane
        wgss_steer_lane wgss_steer_lane_i (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .load(steer_load),
            .enable_request(output_steering_control[wgss_pkg::pos_steer_lsb + ch]),
            .polarity(output_polarity_control[wgss_pkg::pos_polarity_lsb + ch]),
            .override(output_steering_control[wgss_pkg::pos_override_lsb + ch]),
            .data(next_data),
            .next_level(next_channel[ch])
        );
    end

    // ==========================================================
    // source multiplexer, purely combinational; a new selection is
    // seen by the generator on the very next clock
    always_comb begin
        case (input_source_field)
            4'h0: next_data = pin_sync[1];
            4'h1: next_data = sources.capture_compare_output[0];
            4'h2: next_data = sources.capture_compare_output[1];
            4'h3: next_data = sources.capture_compare_output[2];
            4'h4: next_data = sources.capture_compare_output[3];
            4'h5: next_data = sources.capture_compare_output[4];
            4'h6: next_data = sources.pwm_six_output;
            4'h7: next_data = sources.pwm_seven_output;
            4'h8: next_data = sources.numeric_oscillator_output;
            4'h9: next_data = sources.comparator_one_synced;
            4'ha: next_data = sources.comparator_two_synced;
            4'hb: next_data = sources.signal_modulator_output;
            4'hc: next_data = sources.logic_cell_output[0];
            4'hd: next_data = sources.logic_cell_output[1];
            4'he: next_data = sources.logic_cell_output[2];
            default: next_data = sources.logic_cell_output[3];
        endcase
    end

    // ==========================================================
    // outputs registered; one cycle of latency on the data path, bought
    // so that every output leaves this block straight from a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            generator_data_waveform <= 1'b0;
            channel_out <= 4'h0;
            clock_source_fast <= 1'b0;
        end else begin
            generator_data_waveform <= next_data;
            channel_out <= next_channel;
            clock_source_fast <= clock_select;
        end
    end

    // ==========================================================
    // read data, the cycle after the strobe; unmapped reads zero
    // polarity reads also show the live level of the selected input
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                wgss_pkg::off_clock_select: rdata <= {7'h00, clock_select};
                wgss_pkg::off_input_select: rdata <= {4'h0, input_source_field};
                wgss_pkg::off_rising_deadband: rdata <= rising_deadband_count;
                wgss_pkg::off_falling_deadband: rdata <= falling_deadband_count;
                wgss_pkg::off_main_control: rdata <= waveform_main_control;
                wgss_pkg::off_polarity_control: rdata <= output_polarity_control
                    | (8'(next_data) << wgss_pkg::pos_input_status);
                wgss_pkg::off_shutdown_control: rdata <= shutdown_control;
                wgss_pkg::off_shutdown_source: rdata <= shutdown_source_enable;
                wgss_pkg::off_steering_control: rdata <= output_steering_control;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// ==========================================================
// one steering lane: buffered enable flop and output select;
// kept apart so that all four channels are built from one module, one instance per channel
module wgss_steer_lane #(
    parameter logic enable_reset = wgss_pkg::rst_register[0]
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic enable_request,
    input wire logic polarity,
    input wire logic override,
    input wire logic data,
    output logic next_level
);
    logic steer_enable;

    // the enable only moves when load is high; the caller decides when
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            steer_enable <= enable_reset;
        end else if (load) begin
            steer_enable <= enable_request;
        end
    end

    // steered: data through polarity; unsteered: override level
    always_comb begin
        if (steer_enable) begin
            next_level = data ^ polarity;
        end else begin
            next_level = override;
        end
    end
endmodule

// File: test/wgss_src_model.sv
// partner model: on-chip waveform sources driven from a flat pattern
`timescale 1ns/1ns
module wgss_src_model (
    input wire logic [15:0] pattern,
    output wgss_pkg::wgss_sources_type sources
);
    // ==========================================================
    // bit n of the pattern is the waveform behind source code n
    assign sources = {pattern[0], pattern[5:1], pattern[6], pattern[7], pattern[8],
        pattern[9], pattern[10], pattern[11], pattern[15:12]};
endmodule

// File: test/wgss_chk.sv
// checker: port-level properties of the source select block
`timescale 1ns/1ns
module wgss_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wgss_pkg::wgss_bus_type bus,
    input wire logic [7:0] rdata,
    input wgss_pkg::wgss_sources_type sources,
    input wire logic clock_source_fast,
    input wire logic generator_data_waveform,
    input wire logic [3:0] channel_out
);
    logic [3:0] sel;
    logic [15:0] flat;
    logic [7:0] steer;
    logic [2:0] mode;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // shadow of the select field; flat lists sources by code
    assign flat = {sources.logic_cell_output, sources.signal_modulator_output,
        sources.comparator_two_synced, sources.comparator_one_synced,
        sources.numeric_oscillator_output, sources.pwm_seven_output,
        sources.pwm_six_output, sources.capture_compare_output, sources.routed_input_pin};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) sel <= 4'h0;
        else if (bus.wr && bus.addr == wgss_pkg::off_input_select) sel <= bus.wdata[3:0];
    end
    // shadows of the steering byte and the mode field
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            steer <= 8'h00;
            mode <= 3'h0;
        end else if (bus.wr && bus.addr == wgss_pkg::off_steering_control) begin
            steer <= bus.wdata;
        end else if (bus.wr && bus.addr == wgss_pkg::off_main_control) begin
            mode <= bus.wdata[2:0];
        end
    end
    // ==========================================================
    // properties
    chk_clock_write: assert property (bus.wr && bus.addr == wgss_pkg::off_clock_select
        |=> ##1 clock_source_fast == $past(bus.wdata[0], 2))
        else $error("clock select write lost");
    chk_clock_hold: assert property (!(bus.wr && bus.addr == wgss_pkg::off_clock_select)
        |=> ##1 $stable(clock_source_fast)) else $error("clock select moved unasked");
    chk_clock_upper: assert property (bus.rd && bus.addr == wgss_pkg::off_clock_select
        |=> rdata[7:1] == 7'h00) else $error("clock select upper bits set");
    chk_input_upper: assert property (bus.rd && bus.addr == wgss_pkg::off_input_select
        |=> rdata[7:4] == 4'h0) else $error("input select upper bits set");
    chk_input_readback: assert property (bus.rd && bus.addr == wgss_pkg::off_input_select
        |=> rdata[3:0] == $past(sel)) else $error("input select readback wrong");
    chk_reset_zero: assert property ($rose(rst_n)
        |-> !clock_source_fast && channel_out == 4'h0) else $error("outputs not zero at reset");
    chk_data_select: assert property (sel != 4'h0
        |=> generator_data_waveform == $past(flat[sel])) else $error("wrong source routed");
    chk_pin_latency: assert property (sel == 4'h0 [*4]
        |-> generator_data_waveform == $past(sources.routed_input_pin, 3))
        else $error("pin source latency wrong");
    chk_override_out: assert property ((mode != wgss_pkg::mode_buffered_steer
        && steer[3:0] == 4'h0) ##1 (steer[3:0] == 4'h0)
        |=> channel_out == $past(steer[7:4])) else $error("override level not driven");
endmodule

bind wgss_source_select wgss_chk wgss_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .sources(sources), .clock_source_fast(clock_source_fast),
    .generator_data_waveform(generator_data_waveform), .channel_out(channel_out));

// File: test/wgss_source_select_tb.sv
// testbench: register access, source selection and steering
`timescale 1ns/1ns
module wgss_source_select_tb;
    logic clk_sys, rst_n, update_point, clock_source_fast, generator_data_waveform;
    wgss_pkg::wgss_bus_type bus;
    wgss_pkg::wgss_sources_type sources;
    logic [15:0] pattern;
    logic [7:0] rdata;
    logic [3:0] channel_out;
    int failures, tests_run;
    wgss_src_model wgss_src_model_i (.pattern(pattern), .sources(sources));
    wgss_source_select wgss_source_select_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .rdata(rdata), .sources(sources), .internal_fast_oscillator(1'b0),
        .update_point(update_point), .clock_source_fast(clock_source_fast),
        .generator_data_waveform(generator_data_waveform), .channel_out(channel_out));
    // ==========================================================
    // access and compare tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 check("read data", exp, rdata);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // clock and watchdog; the whole run needs well under 1000 cycles
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    // ==========================================================
    // test sequence
    initial begin
        failures = 0;
        tests_run = 0;
        rst_n = 1'b0;
        bus = '0;
        pattern = 16'h0000;
        update_point = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_check(wgss_pkg::off_clock_select, 8'h00);
        rd_check(wgss_pkg::off_input_select, 8'h00);
        wr(wgss_pkg::off_clock_select, 8'hff);
        idle(1);
        check("fast clock", 8'h01, {7'h00, clock_source_fast});
        rd_check(wgss_pkg::off_clock_select, 8'h01);
        wr(wgss_pkg::off_clock_select, 8'h00);
        idle(1);
        check("fast clock", 8'h00, {7'h00, clock_source_fast});
        wr(wgss_pkg::off_input_select, 8'hf3);
        rd_check(wgss_pkg::off_input_select, 8'h03);
        rd_check(4'hf, 8'h00);
        $display("test registers done");
        // each code alone high, then alone low; pin needs the longest wait
        for (int code = 0; code < 16; code++) begin
            @(posedge clk_sys);
            pattern <= 16'h0001 << code;
            wr(wgss_pkg::off_input_select, 8'(code));
            idle(4);
            check("data waveform", 8'h01, {7'h00, generator_data_waveform});
            @(posedge clk_sys);
            pattern <= ~(16'h0001 << code);
            idle(4);
            check("data waveform", 8'h00, {7'h00, generator_data_waveform});
        end
        $display("test sources done");
        // buffered enables wait for the update point
        @(posedge clk_sys);
        pattern <= 16'h0100;
        wr(wgss_pkg::off_input_select, 8'h08);
        wr(wgss_pkg::off_main_control, 8'h01);
        wr(wgss_pkg::off_steering_control, 8'h0f);
        idle(3);
        check("channels", 8'h00, {4'h0, channel_out});
        @(posedge clk_sys);
        update_point <= 1'b1;
        @(posedge clk_sys);
        update_point <= 1'b0;
        idle(2);
        check("channels", 8'h0f, {4'h0, channel_out});
        wr(wgss_pkg::off_polarity_control, 8'h05);
        idle(2);
        check("channels", 8'h0a, {4'h0, channel_out});
        wr(wgss_pkg::off_main_control, 8'h00);
        wr(wgss_pkg::off_steering_control, 8'h50);
        idle(3);
        check("channels", 8'h05, {4'h0, channel_out});
        $display("test steering done");
        tally_and_finish();
    end
endmodule
